// File: shared/twowire_pkg.sv
// Constants, types and the behaviour summary of the two-wire master receiver.
// ****************************************************************
// How it works
// - Interface enable gates all bus activity.
// - START waits until the bus is free.
// - After START, flag set with status 0x08.
// - Address direction bit selects transmit or receive.
// - Hardware sets flag; writing one clears it.
// - Read address done: status 0x38, 0x40, 0x48.
// - In 0x40/0x50 receive byte, ACK per enable.
// - Received byte reports 0x50 on ACK, 0x58 NACK.
// - Received byte readable while flag is set.
// - Last received byte is answered with NACK.
// - Stop request makes STOP, then clears itself.
// - Start without stop makes repeated START, 0x10.
// - In 0x10, read continues; write switches mode.
// - In 0x48/0x58 start plus stop: STOP, START.
// - In 0x48 no data; only START or STOP.
// - In 0x38 release bus, or START when free.
// - Status codes read with prescaler bits zero.
// ****************************************************************
package twowire_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_MHZ = 250; // System clock rate.
	localparam int unsigned T_QUARTER_NS = 40; // Quarter of one serial bit time.
	// Least time, so the count rounds up to whole cycles.
	localparam int unsigned QUARTER_CYC = (T_QUARTER_NS * CLK_MHZ + 999) / 1000;

	// ****************************************************************
	// Register map and fields
	// ****************************************************************
	localparam int unsigned REG_AW = 8; // Decoded address bits.
	localparam logic [7:0] OFS_CTRL = 8'h00; // bus_control.
	localparam logic [7:0] OFS_STAT = 8'h04; // status_code_reg.
	localparam logic [7:0] OFS_DATA = 8'h08; // data_shift_reg.
	localparam int unsigned B_FLAG = 7; // step_done_flag.
	localparam int unsigned B_ACKEN = 6; // ack_enable.
	localparam int unsigned B_START = 5; // start_request.
	localparam int unsigned B_STOP = 4; // stop_request.
	localparam int unsigned B_WCOL = 3; // write_collision_flag.
	localparam int unsigned B_EN = 2; // interface_enable.
	localparam int unsigned B_IE = 0; // interrupt_enable, stored only.
	localparam logic [7:0] DATA_RST = 8'hFF; // Data register after reset.
	localparam logic [2:0] PRESC_ZERO = 3'h0; // Prescaler and spare bits of status.
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2; // AHB transfer kind.

	// ****************************************************************
	// Status codes
	// ****************************************************************
	localparam logic [7:0] ST_NONE = 8'hF8; // Nothing to report.
	localparam logic [7:0] ST_START = 8'h08;
	localparam logic [7:0] ST_RSTART = 8'h10;
	localparam logic [7:0] ST_MT_AACK = 8'h18;
	localparam logic [7:0] ST_MT_ANACK = 8'h20;
	localparam logic [7:0] ST_MT_DACK = 8'h28;
	localparam logic [7:0] ST_MT_DNACK = 8'h30;
	localparam logic [7:0] ST_LOST = 8'h38;
	localparam logic [7:0] ST_MR_AACK = 8'h40;
	localparam logic [7:0] ST_MR_ANACK = 8'h48;
	localparam logic [7:0] ST_MR_DACK = 8'h50;
	localparam logic [7:0] ST_MR_DNACK = 8'h58;

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	localparam logic [1:0] Q0 = 2'h0; // Quarter phases of a bit or condition.
	localparam logic [1:0] Q1 = 2'h1;
	localparam logic [1:0] Q2 = 2'h2;
	localparam logic [1:0] Q3 = 2'h3;
	localparam logic [2:0] LAST_BIT = 3'h7; // Index of the eighth bit.

	typedef struct packed {
		logic scl; // Serial clock level.
		logic sda; // Serial data level.
	} line_t;

	typedef enum logic [2:0] {
		S_IDLE, S_WAIT_FREE, S_START, S_HOLD, S_BIT, S_ACK, S_STOP
	} state_t;

endpackage

// File: hw/line_sync.sv
// Two-flop synchroniser for the serial line levels.
`timescale 1ns/100ps
module line_sync
	import twowire_pkg::*;
(
	input wire logic clk, // System clock.
	input wire logic rst, // Asynchronous reset, high.
	input wire line_t d, // Raw pin levels.
	output line_t q // Synchronised levels.
);
	line_t meta_ff; // First stage, read only by the second.
	line_t q_ff; // Second stage.

	// Idle lines are pulled high, so reset to high levels.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_ff <= '1;
			q_ff <= '1;
		end else begin
			meta_ff <= d;
			q_ff <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule

// File: hw/bus_watch.sv
// Start and stop condition watcher that tells whether the bus is busy.
`timescale 1ns/100ps
module bus_watch
	import twowire_pkg::*;
(
	input wire logic clk, // System clock.
	input wire logic rst, // Asynchronous reset, high.
	input wire line_t ln, // Synchronised line levels.
	output logic busy // Bus held by some master.
);
	line_t prev_ff; // Levels one cycle back.
	logic busy_ff; // Busy between START and STOP.
	logic saw_start; // Data falls while clock high.
	logic saw_stop; // Data rises while clock high.

	assign saw_start = prev_ff.sda & ~ln.sda & ln.scl & prev_ff.scl;
	assign saw_stop = ~prev_ff.sda & ln.sda & ln.scl & prev_ff.scl;

	// A stop frees the bus; a start claims it.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_ff <= '1;
			busy_ff <= 1'b0;
		end else begin
			prev_ff <= ln;
			if (saw_start) begin
				busy_ff <= 1'b1;
			end else if (saw_stop) begin
				busy_ff <= 1'b0;
			end
		end
	end

	assign busy = busy_ff;
endmodule

// File: hw/two_wire_master_receiver.sv
// Two-wire master receiver with an AHB-Lite register slave.
`timescale 1ns/100ps
module two_wire_master_receiver
	import twowire_pkg::*;
#(
	parameter int unsigned QUARTER = QUARTER_CYC // Cycles per quarter bit.
) (
	input wire logic CLOCK, // System clock.
	input wire logic RST, // Asynchronous reset, high.
	input wire logic HSEL, // Slave select.
	input wire logic [31:0] HADDR, // Byte address.
	input wire logic [1:0] HTRANS, // Transfer kind.
	input wire logic HWRITE, // Write when high.
	input wire logic [2:0] HSIZE, // Always a word here.
	input wire logic [31:0] HWDATA, // Write data.
	input wire logic HREADY, // Bus ready.
	output logic [31:0] HRDATA, // Read data.
	output logic HREADYOUT, // Always ready.
	output logic HRESP, // Always OKAY.
	input wire logic SCL_I, // Clock line level.
	output logic SCL_O, // Clock drive value, low.
	output logic SCL_OE, // High while pulling clock low.
	input wire logic SDA_I, // Data line level.
	output logic SDA_O, // Data drive value, low.
	output logic SDA_OE // High while pulling data low.
);
	localparam int unsigned QW = $clog2(QUARTER); // Counter width.
	localparam logic [QW-1:0] Q_LAST = QW'(QUARTER - 1); // Last count.

	// ****************************************************************
	// Pins and bus watch
	// ****************************************************************
	line_t pin_raw; // Raw line levels.
	line_t pin_s; // Synchronised line levels.
	logic bus_busy; // A START seen without STOP, this unit's own included.

	assign pin_raw = '{scl: SCL_I, sda: SDA_I};

	line_sync u_sync (
		.clk(CLOCK),
		.rst(RST),
		.d(pin_raw),
		.q(pin_s)
	);

	bus_watch u_watch (
		.clk(CLOCK),
		.rst(RST),
		.ln(pin_s),
		.busy(bus_busy)
	);

	// ****************************************************************
	// Register state
	// ****************************************************************
	logic flag_ff; // step_done_flag.
	logic acken_ff; // ack_enable.
	logic start_ff; // start_request.
	logic stop_ff; // stop_request.
	logic wcol_ff; // write_collision_flag.
	logic en_ff; // interface_enable.
	logic ie_ff; // interrupt_enable, kept for software only.
	logic [7:0] status_ff; // status_code_reg.
	logic [7:0] data_ff; // data_shift_reg, also the shifter.

	// ****************************************************************
	// AHB-Lite slave
	// ****************************************************************
	logic wr_pend_ff; // Write in its data phase.
	logic [REG_AW-1:0] wr_addr_ff; // Address of that write.
	logic [31:0] hrdata_ff; // Registered read data.
	logic take; // Address phase accepted.
	logic wr_ctrl; // Control write lands now.
	logic wr_data; // Data write lands now.
	logic [7:0] ctrl_rd; // Control as read back.
	logic [7:0] rd_byte; // Selected read byte.
	logic [REG_AW-1:0] rd_addr; // Address being read.

	assign take = HSEL & HTRANS[1] & HREADY;
	assign rd_addr = HADDR[REG_AW-1:0];
	assign wr_ctrl = wr_pend_ff & (wr_addr_ff == OFS_CTRL);
	assign wr_data = wr_pend_ff & (wr_addr_ff == OFS_DATA);
	assign ctrl_rd = {flag_ff, acken_ff, start_ff, stop_ff, wcol_ff, en_ff, 1'b0, ie_ff};
	// The low status bits always read as zero, so codes compare directly.
	assign rd_byte = (rd_addr == OFS_CTRL) ? ctrl_rd :
		(rd_addr == OFS_STAT) ? {status_ff[7:3], PRESC_ZERO} :
		(rd_addr == OFS_DATA) ? data_ff : 8'h00;

	// Zero wait states: read data is caught at the address phase, and a
	// write lands at the end of its data phase. Unmapped reads give zero.
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			wr_pend_ff <= 1'b0;
			wr_addr_ff <= '0;
			hrdata_ff <= 32'h0;
		end else begin
			wr_pend_ff <= take & HWRITE;
			wr_addr_ff <= rd_addr;
			hrdata_ff <= (take & ~HWRITE) ? {24'h0, rd_byte} : 32'h0;
		end
	end

	assign HRDATA = hrdata_ff;

	// Ready and response never change; they still come from flip-flops.
	logic ready_ff; // Constant ready.
	logic resp_ff; // Constant OKAY.
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			ready_ff <= 1'b1;
			resp_ff <= 1'b0;
		end else begin
			ready_ff <= 1'b1;
			resp_ff <= 1'b0;
		end
	end

	assign HREADYOUT = ready_ff;
	assign HRESP = resp_ff;

	// Plain control bits belong to software alone.
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			acken_ff <= 1'b0;
			start_ff <= 1'b0;
			en_ff <= 1'b0;
			ie_ff <= 1'b0;
			wcol_ff <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				acken_ff <= HWDATA[B_ACKEN];
				start_ff <= HWDATA[B_START];
				en_ff <= HWDATA[B_EN];
				ie_ff <= HWDATA[B_IE];
			end
			// A data write while the flag is clear is dropped and flagged.
			if (wr_data) begin
				wcol_ff <= ~flag_ff;
			end
		end
	end

	// ****************************************************************
	// Quarter-bit timer
	// ****************************************************************
	state_t st_ff; // Sequencer state.
	logic [QW-1:0] qcnt_ff; // Cycles within a quarter.
	logic [1:0] phase_ff; // Quarter within a bit.
	logic scl_low_ff; // Pulling the clock line low.
	logic sda_low_ff; // Pulling the data line low.
	logic active; // A bit or condition is on the wire.
	logic stalled; // Clock released but still low.
	logic tick; // End of a quarter.

	assign active = (st_ff == S_START) | (st_ff == S_BIT) | (st_ff == S_ACK) | (st_ff == S_STOP);
	// A slave stretching the clock halts the timer until the line rises.
	assign stalled = ~scl_low_ff & ~pin_s.scl;
	assign tick = active & (qcnt_ff == Q_LAST) & ~stalled;

	// The counter restarts on every quarter and rests outside sequences.
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			qcnt_ff <= '0;
			phase_ff <= Q0;
		end else begin
			if (!active || tick) begin
				qcnt_ff <= '0;
			end else if (!stalled) begin
				qcnt_ff <= qcnt_ff + 1'b1;
			end
			phase_ff <= !active ? Q0 : (tick ? phase_ff + 1'b1 : phase_ff);
		end
	end

	// ****************************************************************
	// Sequencer decisions
	// ****************************************************************
	logic master_ff; // Bus owned by this unit.
	logic rx_ff; // Current byte is received.
	logic addr_ff; // Current byte is an address.
	logic dir_ff; // Direction bit of the address, high to read.
	logic ack_lat_ff; // Acknowledge to return for this byte.
	logic bit_in_ff; // Sampled data bit.
	logic ack_in_ff; // Acknowledge seen from the slave.
	logic is_addr; // Next byte is an address.
	logic is_rx; // Next byte is received.
	logic hold_stay; // No byte may follow this status.
	logic lost_now; // Our released level was pulled low.
	logic last_q; // Final quarter of a sequence.
	logic [7:0] ack_code; // Status after an acknowledge bit.
	logic [2:0] bitcnt_ff; // Bits done in this byte.

	assign is_addr = (status_ff == ST_START) | (status_ff == ST_RSTART);
	assign is_rx = (status_ff == ST_MR_AACK) | (status_ff == ST_MR_DACK);
	assign hold_stay = (status_ff == ST_MR_ANACK) | (status_ff == ST_MR_DNACK);
	assign last_q = tick & (phase_ff == Q3);
	// Arbitration is lost when a released data bit reads low at mid-bit.
	assign lost_now = tick & (phase_ff == Q1) & ~sda_low_ff & ~pin_s.sda &
		(((st_ff == S_BIT) & ~rx_ff) | ((st_ff == S_ACK) & rx_ff));
	assign ack_code = addr_ff ?
		(dir_ff ? (ack_in_ff ? ST_MR_AACK : ST_MR_ANACK) :
			(ack_in_ff ? ST_MT_AACK : ST_MT_ANACK)) :
		rx_ff ? (ack_lat_ff ? ST_MR_DACK : ST_MR_DNACK) :
			(ack_in_ff ? ST_MT_DACK : ST_MT_DNACK);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Bus writes come first so that a hardware set later in the block
	// wins over a clear in the same cycle.
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			st_ff <= S_IDLE;
			flag_ff <= 1'b0;
			stop_ff <= 1'b0;
			status_ff <= ST_NONE;
			data_ff <= DATA_RST;
			scl_low_ff <= 1'b0;
			sda_low_ff <= 1'b0;
			master_ff <= 1'b0;
			rx_ff <= 1'b0;
			addr_ff <= 1'b0;
			dir_ff <= 1'b0;
			ack_lat_ff <= 1'b0;
			bit_in_ff <= 1'b1;
			ack_in_ff <= 1'b0;
			bitcnt_ff <= 3'h0;
		end else begin
			if (wr_ctrl && HWDATA[B_FLAG]) begin
				flag_ff <= 1'b0;
			end
			if (wr_ctrl) begin
				stop_ff <= HWDATA[B_STOP];
			end
			if (wr_data && flag_ff) begin
				data_ff <= HWDATA[7:0];
			end
			if (!en_ff) begin
				// Disabled: the lines are let go and nothing moves.
				st_ff <= S_IDLE;
				scl_low_ff <= 1'b0;
				sda_low_ff <= 1'b0;
				master_ff <= 1'b0;
			end else if (lost_now) begin
				// Lost: let go of both lines and report it.
				scl_low_ff <= 1'b0;
				sda_low_ff <= 1'b0;
				master_ff <= 1'b0;
				flag_ff <= 1'b1;
				status_ff <= ST_LOST;
				st_ff <= S_HOLD;
			end else begin
				unique case (st_ff)
					S_IDLE: begin
						if (!flag_ff && start_ff) begin
							st_ff <= S_WAIT_FREE;
						end
					end
					S_WAIT_FREE: begin
						if (!bus_busy) begin
							st_ff <= S_START;
						end
					end
					S_START: begin
						if (tick) begin
							unique case (phase_ff)
								Q0: sda_low_ff <= 1'b0;
								Q1: scl_low_ff <= 1'b0;
								Q2: sda_low_ff <= 1'b1;
								Q3: begin
									scl_low_ff <= 1'b1;
									flag_ff <= 1'b1;
									status_ff <= master_ff ? ST_RSTART : ST_START;
									master_ff <= 1'b1;
									st_ff <= S_HOLD;
								end
							endcase
						end
					end
					S_HOLD: begin
						// While this unit is master, the clock stays low until software clears the flag.
						if (!flag_ff) begin
							if (!master_ff) begin
								scl_low_ff <= 1'b0;
								sda_low_ff <= 1'b0;
								st_ff <= S_IDLE;
							end else if (stop_ff) begin
								st_ff <= S_STOP;
							end else if (start_ff) begin
								st_ff <= S_START;
							end else if (!hold_stay) begin
								st_ff <= S_BIT;
								bitcnt_ff <= 3'h0;
								addr_ff <= is_addr;
								dir_ff <= data_ff[0];
								rx_ff <= is_rx;
								ack_lat_ff <= acken_ff;
								sda_low_ff <= ~is_rx & ~data_ff[7];
							end
						end
					end
					S_BIT: begin
						if (tick) begin
							unique case (phase_ff)
								Q0: scl_low_ff <= 1'b0;
								Q1: bit_in_ff <= pin_s.sda;
								Q2: scl_low_ff <= 1'b1;
								Q3: begin
									data_ff <= {data_ff[6:0], bit_in_ff};
									bitcnt_ff <= bitcnt_ff + 1'b1;
									if (bitcnt_ff == LAST_BIT) begin
										st_ff <= S_ACK;
										sda_low_ff <= rx_ff & ack_lat_ff;
									end else begin
										sda_low_ff <= ~rx_ff & ~data_ff[6];
									end
								end
							endcase
						end
					end
					S_ACK: begin
						if (tick) begin
							unique case (phase_ff)
								Q0: scl_low_ff <= 1'b0;
								Q1: ack_in_ff <= ~pin_s.sda;
								Q2: scl_low_ff <= 1'b1;
								Q3: begin
									sda_low_ff <= 1'b0;
									flag_ff <= 1'b1;
									status_ff <= ack_code;
									st_ff <= S_HOLD;
								end
							endcase
						end
					end
					S_STOP: begin
						if (tick) begin
							unique case (phase_ff)
								Q0: sda_low_ff <= 1'b1;
								Q1: scl_low_ff <= 1'b0;
								Q2: sda_low_ff <= 1'b0;
								Q3: begin
									stop_ff <= 1'b0;
									master_ff <= 1'b0;
									status_ff <= ST_NONE;
									st_ff <= start_ff ? S_WAIT_FREE : S_IDLE;
								end
							endcase
						end
					end
				endcase
			end
		end
	end


	// Open-drain pins: only ever drive low.
	logic scl_o_ff; // Constant low drive value.
	logic sda_o_ff; // Constant low drive value.
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			scl_o_ff <= 1'b0;
			sda_o_ff <= 1'b0;
		end else begin
			scl_o_ff <= 1'b0;
			sda_o_ff <= 1'b0;
		end
	end

	assign SCL_O = scl_o_ff;
	assign SDA_O = sda_o_ff;
	assign SCL_OE = scl_low_ff;
	assign SDA_OE = sda_low_ff;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);

	disabled_quiet_a: assert property (
		!en_ff |=> !scl_low_ff && !sda_low_ff)
		else $error("Lines driven while disabled.");

	wait_free_a: assert property (
		(st_ff == S_WAIT_FREE && bus_busy && en_ff) |=> st_ff == S_WAIT_FREE)
		else $error("START issued on a busy bus.");

	start_status_a: assert property (
		(st_ff == S_START && last_q && !master_ff && en_ff) |=> flag_ff && status_ff == ST_START)
		else $error("START not reported as 0x08.");

	rstart_status_a: assert property (
		(st_ff == S_START && last_q && master_ff && en_ff) |=> flag_ff && status_ff == ST_RSTART)
		else $error("Repeated START not reported as 0x10.");

	flag_clear_a: assert property (
		(wr_ctrl && HWDATA[B_FLAG] && !last_q && !lost_now) |=> !flag_ff)
		else $error("Writing one did not clear the flag.");

	addr_status_a: assert property (
		(st_ff == S_ACK && addr_ff && dir_ff && last_q && en_ff)
		|=> status_ff == ST_MR_AACK || status_ff == ST_MR_ANACK)
		else $error("Bad status after read address.");

	mode_switch_a: assert property (
		(st_ff == S_ACK && addr_ff && !dir_ff && last_q && en_ff)
		|=> status_ff == ST_MT_AACK || status_ff == ST_MT_ANACK)
		else $error("Write address did not enter transmit mode.");

	ack_drive_a: assert property (
		(st_ff == S_ACK && rx_ff && en_ff) |-> sda_low_ff == ack_lat_ff)
		else $error("Returned acknowledge differs from enable.");

	rx_status_a: assert property (
		(st_ff == S_ACK && rx_ff && !addr_ff && last_q && en_ff)
		|=> status_ff == (ack_lat_ff ? ST_MR_DACK : ST_MR_DNACK))
		else $error("Wrong status after received byte.");

	data_stable_a: assert property (
		(st_ff == S_HOLD && flag_ff && !wr_data) |=> $stable(data_ff))
		else $error("Data changed while flag set.");

	stop_clear_a: assert property (
		(st_ff == S_STOP && last_q && en_ff) |=> !stop_ff && !master_ff)
		else $error("Stop request not cleared after STOP.");

	stop_start_a: assert property (
		(st_ff == S_STOP && last_q && start_ff && en_ff) |=> st_ff == S_WAIT_FREE)
		else $error("No START after STOP.");

	nack_hold_a: assert property (
		(st_ff == S_HOLD && !flag_ff && master_ff && en_ff && !stop_ff && !start_ff && hold_stay)
		|=> st_ff == S_HOLD)
		else $error("Data moved after a NACK status.");

	lost_release_a: assert property (
		(st_ff == S_HOLD && !flag_ff && !master_ff && en_ff)
		|=> !scl_low_ff && !sda_low_ff && st_ff == S_IDLE)
		else $error("Bus not released after loss.");

	hold_stretch_a: assert property (
		(flag_ff && master_ff && en_ff) |-> scl_low_ff)
		else $error("Clock released while flag set.");
endmodule

// File: verification/slave_tx_model.sv
// Behavioural slave transmitter on the two-wire bus.
`timescale 1ns/100ps
module slave_tx_model #(
	parameter logic [6:0] ADDR = 7'h52 // Own address, arbitrary.
) (
	input wire logic scl, // Clock line level.
	input wire logic sda, // Data line level.
	input wire logic [7:0] seed, // Base of the data pattern.
	input wire logic [7:0] stretch, // Low-phase stretch in ns.
	output logic scl_low, // Pulls the clock line low.
	output logic sda_low // Pulls the data line low.
);
	int cnt = 0; // Bit index within the byte.
	logic act = 0; // Taking part in a transfer.
	logic rd = 0; // Address done, sending data.
	logic [7:0] sr = 8'h00; // Received bits.
	logic [7:0] k = 8'h00; // Index of the byte being sent.
	logic [7:0] cur = 8'h00; // Byte being sent.
	initial begin
		scl_low = 0;
		sda_low = 0;
	end
	// Data pattern; the bench predicts it on its own.
	function automatic logic [7:0] byte_of(input logic [7:0] i);
		return seed + i * 8'h3B;
	endfunction
	// A START or STOP restarts framing; levels are tested hard against unknowns.
	always @(sda) if (scl === 1'b1) begin
		act = (sda === 1'b0);
		rd = 0;
		cnt = 0;
		sda_low = 0;
	end
	// Sample on the rising edge; a released acknowledge ends the read.
	always @(posedge scl) if (act) begin
		if (cnt < 8) sr = {sr[6:0], sda};
		else if (rd && sda) act = 0;
		cnt = cnt + 1;
	end
	// Drive on the falling edge, so data never moves while the clock is high.
	always @(negedge scl) if (act) begin
		if (stretch > 0) scl_low = 1;
		if (cnt == 9) begin
			if (rd) k = k + 1;
			else k = 0;
			act = rd | sda_low;
			rd = 1;
			cnt = 0;
		end
		// Only a read packet to our own address is acknowledged.
		cur = byte_of(k);
		sda_low = act && (rd ? (cnt < 8 && !cur[7 - cnt]) : (cnt == 8 && sr == {ADDR, 1'b1}));
		#(stretch) scl_low = 0;
	end
endmodule

// File: verification/two_wire_master_receiver_bench.sv
// Self-checking bench of the master receiver against the slave model.
`timescale 1ns/100ps
module two_wire_master_receiver_bench;
	import twowire_pkg::*;
	localparam logic [6:0] SLV = 7'h52; // Slave address, arbitrary.
	logic clock = 0; // System clock.
	logic rst = 1; // Reset.
	logic hsel = 0; // Select.
	logic hwrite = 0; // Direction.
	logic [31:0] haddr = 32'h0; // Address.
	logic [1:0] htrans = 2'h0; // Transfer kind.
	logic [31:0] hwdata = 32'h0; // Write data.
	logic [31:0] hrdata; // Read data.
	logic hready; // Ready, fed back.
	logic scl_oe, sda_oe, s_scl, s_sda; // Pull-down enables.
	logic [7:0] seed = 8'h00; // Slave pattern base.
	logic [7:0] stretch = 8'h00; // Slave stretch.
	int fails = 0;
	int samples_checked = 0;
	wire scl = !scl_oe && !s_scl; // Pulled-up wired AND.
	wire sda = !sda_oe && !s_sda; // Pulled-up wired AND.
	always #2 clock = !clock;
	two_wire_master_receiver i_two_wire_master_receiver (.CLOCK(clock), .RST(rst),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
		.HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(),
		.SCL_I(scl), .SCL_O(), .SCL_OE(scl_oe), .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe));
	slave_tx_model #(.ADDR(SLV)) i_slave_tx_model (.scl(scl), .sda(sda), .seed(seed),
		.stretch(stretch), .scl_low(s_scl), .sda_low(s_sda));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One AHB single; ready and read data are taken at the rising edge itself.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [31:0] r);
		hsel <= 1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clock); while (hready !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do begin @(posedge clock); r = hrdata; end while (hready !== 1'b1);
	endtask
	// The idle cycle lets a write land before the next address phase reads.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		xfer(1, a, d, r);
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		xfer(0, a, 8'h00, r);
		chk(r, exp);
	endtask
	// Poll the flag; a bounded count keeps a stuck flag from hanging here.
	task automatic wait_flag(input logic [7:0] code);
		logic [31:0] r;
		int n = 0;
		do begin xfer(0, OFS_CTRL, 8'h00, r); n++; end while (r[B_FLAG] !== 1'b1 && n < 3000);
		chk({31'h0, r[B_FLAG]}, 32'h1);
		chk({31'h0, scl_oe}, 32'h1);
		rd(OFS_STAT, {24'h0, code});
	endtask
	// Address a slave for reading and take n bytes, the last one refused; another address only waits for 0x48.
	task automatic rx(input int n, input logic [6:0] a);
		wr(OFS_DATA, {a, 1'b1});
		wr(OFS_CTRL, 8'h84);
		if (a != SLV) begin
			wait_flag(ST_MR_ANACK);
			return;
		end
		wait_flag(ST_MR_AACK);
		for (int k = 0; k < n; k++) begin
			wr(OFS_CTRL, k < n - 1 ? 8'hC4 : 8'h84);
			wait_flag(k < n - 1 ? ST_MR_DACK : ST_MR_DNACK);
			rd(OFS_DATA, {24'h0, 8'(seed + 8'(k) * 8'h3B)});
		end
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// At least eight times the expected run, far below the overall cycle cap.
	initial begin
		#240000;
		fails++;
		give_verdict;
	end
	initial begin
		seed = 8'($urandom(35));
		repeat (3) @(posedge clock);
		rst <= 0;
		@(posedge clock);
		rd(OFS_CTRL, 32'h0);
		rd(OFS_STAT, {24'h0, ST_NONE});
		rd(OFS_DATA, {24'h0, DATA_RST});
		rd(8'h0C, 32'h0);
		wr(OFS_CTRL, 8'hA0);
		repeat (200) @(posedge clock);
		rd(OFS_STAT, {24'h0, ST_NONE});
		chk({30'h0, scl_oe, sda_oe}, 32'h0);
		wr(OFS_DATA, 8'h55);
		rd(OFS_CTRL, 32'h28);
		$display("test idle done");
		stretch = 8'($urandom_range(200, 0));
		wr(OFS_CTRL, 8'hA4);
		wait_flag(ST_START);
		rx($urandom_range(3, 1), SLV);
		wr(OFS_CTRL, 8'hB4);
		wait_flag(ST_START);
		stretch = 8'($urandom_range(200, 0));
		rx(2, SLV);
		$display("test reads done");
		wr(OFS_CTRL, 8'hA4);
		wait_flag(ST_RSTART);
		rx(1, SLV ^ 7'h01);
		wr(OFS_CTRL, 8'hA4);
		wait_flag(ST_RSTART);
		wr(OFS_DATA, {SLV, 1'b0});
		wr(OFS_CTRL, 8'h84);
		wait_flag(ST_MT_ANACK);
		wr(OFS_CTRL, 8'h94);
		repeat (200) @(posedge clock);
		rd(OFS_CTRL, 32'h04);
		rd(OFS_STAT, {24'h0, ST_NONE});
		chk({30'h0, scl, sda}, 32'h3);
		$display("test stop done");
		give_verdict;
	end
endmodule
